// >>> shared/ssd_pkg.sv
/*
 Constants shared by the serial status/data port and its receive FIFO.
 Assumes one 50 MHz clock and an I/O register space with a data-space alias.
*/
// What this block does
// - Transfer-complete flag, status bit 7, sets when a byte transfer finishes.
// - Interrupt request while flag set, unit interrupt enable and global enable both set.
// - Master with slave-select input driven low also sets transfer-complete flag.
// - Flag clears when the processor enters the matching interrupt vector.
// - Status read with flag set, then data access, clears the flag.
// - Write-collision flag, status bit 6, sets on data write during transfer.
// - Status read with collision set, then data access, clears both flags.
// - Double-rate bit, status bit 0, doubles master SCK rate.
// - Shortest master SCK period equals two CPU clock periods.
// - Data register write loads shift register and starts transmission.
// - Data register read returns the receive buffer, not the written byte.
// - Data register is eight bits, read/write, undefined at reset, bit 7 MSB.
// - Data register at I/O offset 0x0F, data space 0x2F.
// - Master SCK divides clock by 4/16/64/128, halved with double rate.
// - Master slave-select fault clears master bit, pins MOSI and SCK become inputs.
// - Slave deselect resets send/receive logic and drops the partial byte.
package ssd_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h0d;
    localparam logic [7:0] OFF_STAT = 8'h0e;
    localparam logic [7:0] OFF_DATA = 8'h0f;
    localparam logic [7:0] DS_OFFSET = 8'h20;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic STAT_RST = 1'b0;
    localparam int CTRL_IE = 7;
    localparam int CTRL_EN = 6;
    localparam int CTRL_DORD = 5;
    localparam int CTRL_MASTER_SELECT_BIT = 4;
    localparam int CTRL_CPOL = 3;
    localparam int CTRL_CPHA = 2;
    localparam int STAT_DONE = 7;
    localparam int STAT_WRITE_COLLISION_FLAG = 6;
    localparam int STAT_DBL = 0;
    // ****************************************
    // Timing
    // ****************************************
    // Half SCK period in clocks, indexed by {double_rate_bit, rate_select_hi, rate_select_lo}
    localparam logic [6:0] SCK_HALF [0:7] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                              7'h01, 7'h04, 7'h10, 7'h20};
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam int FIFO_DEPTH = 32;
endpackage : ssd_pkg

// >>> shared/ssd_stream_if.sv
/*
 Valid/ready byte stream between the port logic and its receive FIFO.
 Assumes both ends share one clock.
*/
interface ssd_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : ssd_stream_if

// >>> core/ssd_rx_fifo.sv
/*
 Receive FIFO with parameter width and depth (depth a power of two).
 Assumes a synchronous active-low reset and one clock.
*/
module ssd_rx_fifo #(
    parameter int W = 8,
    parameter int DEPTH = ssd_pkg::FIFO_DEPTH
) (
    input wire logic clk,          // System clock
    input wire logic resetn,       // Synchronous reset, active low
    ssd_stream_if.snk in_s,        // Filling side
    ssd_stream_if.src out_s        // Draining side
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic empty;
    logic full;

    assign empty = (wp == rp);
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem[rp[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_s.valid && !full) begin
            mem[wp[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_s.valid && !full) begin
                wp <= wp + 1'b1;
            end
            if (out_s.ready && !empty) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule : ssd_rx_fifo

// >>> core/ssd_spi_port.sv
/*
 Serial master/slave port: control, status and data registers on the I/O
 register port, shift engine on SCK/MOSI/MISO/SS, receive FIFO behind data.
 Assumes pins are synchronous to clk and an external master honours the
 slave SCK limit of a quarter of clk.
*/
module ssd_spi_port (
    input wire logic clk,              // System clock, 50 MHz
    input wire logic resetn,           // Synchronous reset, active low
    input wire logic [7:0] io_addr,    // Register address
    input wire logic io_data_space,    // Address is a data-space address
    input wire logic io_wr,            // Write strobe
    input wire logic io_rd,            // Read strobe
    input wire logic [7:0] io_wdata,   // Write data
    output logic [7:0] io_rdata,       // Read data, valid cycle after io_rd
    input wire logic global_ie,        // Global interrupt enable
    input wire logic int_ack,          // Interrupt vector entered
    output logic irq,                  // Interrupt request
    input wire logic ss_is_input,      // Slave select pin set as input
    input wire logic ss_n_in,          // Slave select level, active low
    input wire logic sck_in,           // SCK pin level
    output logic sck_out,              // SCK drive value
    output logic sck_oe_n,             // SCK drive enable, active low
    input wire logic mosi_in,          // MOSI pin level
    output logic mosi_out,             // MOSI drive value
    output logic mosi_oe_n,            // MOSI drive enable, active low
    input wire logic miso_in,          // MISO pin level
    output logic miso_out,             // MISO drive value
    output logic miso_oe_n             // MISO drive enable, active low
);
    // ****************************************
    // State
    // ****************************************
    logic [7:0] ctrl;
    logic xfer_done_flag;
    logic write_collision_flag;
    logic double_rate_bit;
    logic arm_clear;
    logic [7:0] sh;
    logic out_q;
    logic running;
    logic tx_pend;
    logic [3:0] edge_cnt;
    logic [6:0] div_cnt;
    logic sck_q;
    logic sck_prev;
    logic push_v;

    ssd_stream_if #(.W(8)) rx_in ();
    ssd_stream_if #(.W(8)) rx_out ();

    function automatic logic hit(input logic [7:0] off);
        hit = (io_addr == (io_data_space ? off + ssd_pkg::DS_OFFSET : off));
    endfunction : hit

    function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
        out_bit = lsb_first ? v[0] : v[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shift_in

    // ****************************************
    // Decode
    // ****************************************
    logic en, is_master, dord, cpol, cpha;
    logic sel_ctrl, sel_stat, sel_data, dwr, drd, srd, clr;
    logic fault, slave_act, mtick, sedge, tick, samp_edge, setup_edge, last;
    logic in_bit, busy, accept, start;
    logic [6:0] half;

    assign en = ctrl[ssd_pkg::CTRL_EN];
    assign is_master = ctrl[ssd_pkg::CTRL_MASTER_SELECT_BIT];
    assign dord = ctrl[ssd_pkg::CTRL_DORD];
    assign cpol = ctrl[ssd_pkg::CTRL_CPOL];
    assign cpha = ctrl[ssd_pkg::CTRL_CPHA];
    assign sel_ctrl = hit(ssd_pkg::OFF_CTRL);
    assign sel_stat = hit(ssd_pkg::OFF_STAT);
    assign sel_data = hit(ssd_pkg::OFF_DATA);
    assign dwr = io_wr && sel_data;
    assign drd = io_rd && sel_data;
    assign srd = io_rd && sel_stat;
    assign clr = arm_clear && (dwr || drd);
    assign fault = en && is_master && ss_is_input && !ss_n_in;
    assign slave_act = en && !is_master && !ss_n_in;
    assign half = ssd_pkg::SCK_HALF[{double_rate_bit, ctrl[1:0]}];
    assign mtick = running && (div_cnt == half - 7'h01);
    // Slave relies on SCK at most a quarter of clk so no edge is missed
    assign sedge = slave_act && (sck_in != sck_prev);
    assign tick = mtick || sedge;
    assign samp_edge = tick && (edge_cnt[0] == cpha);
    assign setup_edge = tick && (edge_cnt[0] != cpha);
    assign last = tick && (edge_cnt == ssd_pkg::LAST_EDGE);
    assign in_bit = is_master ? miso_in : mosi_in;
    assign busy = running || tx_pend || (slave_act && edge_cnt != 4'h0);
    assign accept = dwr && !busy && en;
    // A new master byte waits for FIFO room, so a finished master byte is never lost
    assign start = tx_pend && rx_in.ready && !fault;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl <= ssd_pkg::CTRL_RST;
        end else begin
            if (io_wr && sel_ctrl) begin
                ctrl <= io_wdata;
            end
            if (fault) begin
                ctrl[ssd_pkg::CTRL_MASTER_SELECT_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            double_rate_bit <= ssd_pkg::STAT_RST;
        end else if (io_wr && sel_stat) begin
            double_rate_bit <= io_wdata[ssd_pkg::STAT_DBL];
        end
    end

    // Hardware set wins over any clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            xfer_done_flag <= ssd_pkg::STAT_RST;
        end else if (push_v || fault) begin
            xfer_done_flag <= 1'b1;
        end else if (int_ack || clr) begin
            xfer_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            write_collision_flag <= ssd_pkg::STAT_RST;
        end else if (dwr && busy) begin
            write_collision_flag <= 1'b1;
        end else if (clr) begin
            write_collision_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            arm_clear <= 1'b0;
        end else if (srd) begin
            arm_clear <= xfer_done_flag || write_collision_flag;
        end else if (dwr || drd) begin
            arm_clear <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            if (sel_ctrl) begin
                io_rdata <= ctrl;
            end else if (sel_stat) begin
                io_rdata <= {xfer_done_flag, write_collision_flag, 5'h00, double_rate_bit};
            end else if (sel_data) begin
                io_rdata <= rx_out.data;
            end else begin
                io_rdata <= 8'h00;
            end
        end
    end

    assign irq = xfer_done_flag && ctrl[ssd_pkg::CTRL_IE] && global_ie;

    // ****************************************
    // Shift engine
    // ****************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_pend <= 1'b0;
        end else if (fault || !en || !is_master || start) begin
            tx_pend <= 1'b0;
        end else if (accept) begin
            tx_pend <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            running <= 1'b0;
            edge_cnt <= 4'h0;
            div_cnt <= 7'h00;
        end else if (fault || !en) begin
            running <= 1'b0;
            edge_cnt <= 4'h0;
            div_cnt <= 7'h00;
        end else if (start) begin
            running <= 1'b1;
            edge_cnt <= 4'h0;
            div_cnt <= 7'h00;
        end else if (!running && !slave_act) begin
            edge_cnt <= 4'h0;
        end else if (tick) begin
            edge_cnt <= edge_cnt + 4'h1;
            div_cnt <= 7'h00;
            if (last) begin
                running <= 1'b0;
            end
        end else if (running) begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    // Colliding writes are refused here, so the byte in flight is kept
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sh <= 8'h00;
        end else if (accept) begin
            sh <= io_wdata;
        end else if (samp_edge) begin
            sh <= shift_in(sh, in_bit, dord);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            out_q <= 1'b0;
        end else if (accept && !cpha) begin
            out_q <= out_bit(io_wdata, dord);
        end else if (setup_edge) begin
            out_q <= out_bit(sh, dord);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sck_q <= 1'b0;
        end else if (!running) begin
            sck_q <= cpol;
        end else if (mtick) begin
            sck_q <= !sck_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sck_prev <= 1'b0;
            push_v <= 1'b0;
        end else begin
            sck_prev <= sck_in;
            push_v <= last && !fault;
        end
    end

    // ****************************************
    // Receive FIFO and pins
    // ****************************************
    assign rx_in.data = sh;
    assign rx_in.valid = push_v;
    assign rx_out.ready = drd;

    ssd_rx_fifo #(.W(8), .DEPTH(ssd_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_s(rx_in.snk),
        .out_s(rx_out.src)
    );

    assign sck_out = sck_q;
    assign mosi_out = out_q;
    assign miso_out = out_q;
    assign sck_oe_n = !(en && is_master);
    assign mosi_oe_n = !(en && is_master);
    assign miso_oe_n = !slave_act;

    // ****************************************
    // Assertions
    // ****************************************
    property p_done_sets;
        @(posedge clk) disable iff (!resetn) last && !fault |=> ##1 xfer_done_flag;
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done flag not set");

    property p_irq;
        @(posedge clk) disable iff (!resetn)
            push_v && ctrl[ssd_pkg::CTRL_IE] && global_ie ##1 ctrl[ssd_pkg::CTRL_IE] && global_ie |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_fault;
        @(posedge clk) disable iff (!resetn)
            fault |=> !is_master && xfer_done_flag && sck_oe_n && mosi_oe_n && !running;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not handled");

    property p_ack_clears;
        @(posedge clk) disable iff (!resetn) int_ack && !push_v && !fault |=> !xfer_done_flag;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

    property p_clear_seq;
        @(posedge clk) disable iff (!resetn)
            srd && write_collision_flag ##1 !io_rd && !io_wr
            ##1 (dwr || drd) && !push_v && !fault && !busy
            |=> !xfer_done_flag && !write_collision_flag;
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("clear sequence failed");

    property p_collide;
        @(posedge clk) disable iff (!resetn)
            dwr && running && !fault && !last |=> write_collision_flag && running;
    endproperty
    a_collide: assert property (p_collide) else $error("collision mishandled");

    property p_fast_sck;
        @(posedge clk) disable iff (!resetn)
            mtick && half == 7'h01 && !last && !fault && en && !io_wr |=> mtick;
    endproperty
    a_fast_sck: assert property (p_fast_sck) else $error("double rate too slow");

    property p_start;
        @(posedge clk) disable iff (!resetn)
            accept && is_master && !fault && rx_in.ready && !push_v
            |=> ##1 running || !en || !is_master;
    endproperty
    a_start: assert property (p_start) else $error("write did not start");

    property p_deselect;
        @(posedge clk) disable iff (!resetn)
            en && !is_master && ss_n_in |=> edge_cnt == 4'h0;
    endproperty
    a_deselect: assert property (p_deselect) else $error("slave not reset");
endmodule : ssd_spi_port

// >>> tb/ssd_spi_partner.sv
/*
 Far-side serial device: a slave answering a master port, or a master
 clocking a slave port, mode 0, most significant bit first.
 Assumes the bench loads sh and selects it while the link is idle.
*/
module ssd_spi_partner (
    input wire logic clk,      // System clock
    input wire logic sel,      // Selected as slave
    input wire logic sck_w,    // Resolved SCK line
    input wire logic mosi_w,   // Resolved MOSI line
    input wire logic miso_w,   // Resolved MISO line
    output logic p_sck,        // SCK when master
    output logic p_mosi,       // MOSI drive
    output logic p_miso,       // MISO drive
    output logic p_ss_n        // Slave select out, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh = 8'h00, got = 8'h00, rx = 8'h00;
    int bits = 0, cnt = 0, per = 0;
    logic sck_q = 1'b0, m_act = 1'b0, idl = 1'b0;
    initial begin
        p_sck = 1'b0;
        p_ss_n = 1'b1;
        p_mosi = 1'b0;
    end
    // Released lines toggle so a stale level never passes for data
    always @(posedge clk) begin
        idl <= ~idl;
        if (!m_act) p_mosi <= ~p_mosi;
        cnt <= (sck_w && !sck_q) ? 1 : cnt + 1;
        if (sck_w && !sck_q) per <= cnt;
        sck_q <= sck_w;
    end
    assign p_miso = sel ? sh[7] : idl;
    always @(posedge sck_w) if (sel) begin
        rx = {rx[6:0], mosi_w};
        bits = (bits + 1) % 8;
        if (bits == 0) got = rx;
    end
    always @(negedge sck_w) if (sel) sh = sh << 1;
    task automatic send(input logic [7:0] tx, input int n, output logic [7:0] r);
        logic [7:0] t;
        t = tx;
        m_act = 1'b1;
        p_ss_n = 1'b0;
        p_mosi = t[7];
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            #1 r = {r[6:0], miso_w};
            p_sck = 1'b1;
            repeat (4) @(posedge clk);
            #1 p_sck = 1'b0;
            t = t << 1;
            p_mosi = t[7];
        end
        repeat (4) @(posedge clk);
        #1 p_ss_n = 1'b1;
        m_act = 1'b0;
        // Deselect must be seen at a clock edge before the next frame
        repeat (2) @(posedge clk);
        #1;
    endtask : send
endmodule : ssd_spi_partner

// >>> tb/test_spi_status_and_data_port.sv
/*
 Self-checking bench for the serial status/data port and its FIFO.
 Assumes the shared package, interface and design files come first.
*/
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
end
module test_spi_status_and_data_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] CT = 9'h00d, ST = 9'h00e, DT = 9'h00f, DTS = 9'h12f;
    localparam int DIV [4] = '{4, 16, 64, 128};
    logic clk = 1'b0, resetn = 1'b0, io_data_space, io_wr, io_rd, global_ie, int_ack;
    logic ss_is_input, ss_f, slv_sel, irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n;
    logic miso_out, miso_oe_n, p_sck, p_mosi, p_miso, p_ss_n, bad;
    logic [7:0] io_addr, io_wdata, io_rdata, s, d, tx, rp;
    logic [7:0] q [$];
    logic [31:0] seed = 32'h0000c58f;
    logic [2:0] r;
    int num_errors = 0, cmp_count = 0;
    wire sck_w = sck_oe_n ? p_sck : sck_out;
    wire mosi_w = mosi_oe_n ? p_mosi : mosi_out;
    wire miso_w = miso_oe_n ? p_miso : miso_out;
    always #10 clk = ~clk;
    ssd_spi_port ssd_spi_port_i (.clk(clk), .resetn(resetn), .io_addr(io_addr),
        .io_data_space(io_data_space), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .global_ie(global_ie),
        .int_ack(int_ack), .irq(irq), .ss_is_input(ss_is_input),
        .ss_n_in(p_ss_n & ss_f), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n));
    ssd_spi_partner ssd_spi_partner_i (.clk(clk), .sel(slv_sel), .sck_w(sck_w),
        .mosi_w(mosi_w), .miso_w(miso_w), .p_sck(p_sck), .p_mosi(p_mosi),
        .p_miso(p_miso), .p_ss_n(p_ss_n));
    // ****
    // Helpers
    // ****
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function logic [7:0] rev8(input logic [7:0] v);
        for (int k = 0; k < 8; k++) begin
            rev8[k] = v[7 - k];
        end
    endfunction : rev8
    task finish_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task wr(input logic [8:0] a, input logic [7:0] v);
        {io_data_space, io_addr} = a;
        io_wdata = v;
        io_wr = 1'b1;
        @(posedge clk) #1 io_wr = 1'b0;
        @(posedge clk) #1;
    endtask : wr
    task rd(input logic [8:0] a, output logic [7:0] v);
        {io_data_space, io_addr} = a;
        io_rd = 1'b1;
        @(posedge clk) #1 io_rd = 1'b0;
        v = io_rdata;
        @(posedge clk) #1;
    endtask : rd
    // Polls status; a run-out counts as a mismatch
    task wd();
        int n;
        n = 0;
        do begin
            rd(ST, s);
            n++;
        end while (!s[7] && n < 3000);
        if (!s[7]) begin
            num_errors++;
            finish_test();
        end
    endtask : wd
    // ****
    // Scenarios
    // ****
    initial begin
        {io_data_space, io_addr, io_wdata, io_wr, io_rd, int_ack} = '0;
        {global_ie, ss_is_input, ss_f, slv_sel} = 4'hf;
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        rd(CT, d);
        `CHK(d, 8'h00)
        rd(ST, s);
        `CHK(s, 8'h00)
        `CHK({irq, sck_oe_n, mosi_oe_n, miso_oe_n}, 4'h7)
        wr(ST, 8'hff);
        rd(ST, s);
        `CHK(s, 8'h01)
        rd(9'h010, d);
        `CHK(d, 8'h00)
        // Every rate, then fill the FIFO until the start stalls
        for (int i = 0; i < 33; i++) begin
            r = (i < 8) ? i[2:0] : 3'h4;
            wr(CT, {6'h34, r[1:0]});
            wr(ST, {7'h00, r[2]});
            tx = 8'(xs());
            rp = 8'(xs());
            ssd_spi_partner_i.sh = rp;
            q.push_back(rp);
            wr(i[0] ? DTS : DT, tx);
            if (i < 32) begin
                wd();
                `CHK(s, 8'h80 | {7'h00, r[2]})
                `CHK(irq, 1'b1)
                `CHK(ssd_spi_partner_i.got, tx)
                `CHK(ssd_spi_partner_i.per, DIV[r[1:0]] >> r[2])
            end
        end
        bad = 1'b0;
        repeat (40) begin
            rd(ST, s);
            bad |= s[7];
        end
        `CHK(bad, 1'b0)
        for (int i = 0; i < 33; i++) begin
            rd(i[0] ? DTS : DT, d);
            rp = q.pop_front();
            `CHK(d, rp)
            if (i == 0) wd();
        end
        `CHK(ssd_spi_partner_i.got, tx)
        rd(ST, s);
        `CHK(s, 8'h01)
        // Second write while shifting
        wr(ST, 8'h00);
        rp = 8'(xs());
        tx = 8'(xs());
        ssd_spi_partner_i.sh = rp;
        wr(DT, tx);
        wr(DT, ~tx);
        wd();
        `CHK(s, 8'hc0)
        `CHK(ssd_spi_partner_i.got, tx)
        rd(DT, d);
        `CHK(d, rp)
        rd(ST, s);
        `CHK(s, 8'h00)
        // Least significant bit first against a most-significant-first partner
        wr(CT, 8'hf0);
        rp = 8'(xs());
        tx = 8'(xs());
        ssd_spi_partner_i.sh = rp;
        wr(DT, tx);
        wd();
        `CHK(ssd_spi_partner_i.got, rev8(tx))
        rd(DT, d);
        `CHK(d, rev8(rp))
        wr(CT, 8'hd0);
        // Global mask and vector entry
        global_ie = 1'b0;
        rp = 8'(xs());
        ssd_spi_partner_i.sh = rp;
        wr(DT, 8'(xs()));
        wd();
        `CHK(irq, 1'b0)
        global_ie = 1'b1;
        #1 `CHK(irq, 1'b1)
        @(posedge clk) #1 int_ack = 1'b1;
        @(posedge clk) #1 int_ack = 1'b0;
        `CHK(irq, 1'b0)
        rd(DT, d);
        `CHK(d, rp)
        // Select pulled low under a master
        ss_f = 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK({sck_oe_n, mosi_oe_n}, 2'h3)
        ss_f = 1'b1;
        rd(CT, d);
        `CHK(d, 8'hc0)
        rd(ST, s);
        `CHK(s, 8'h80)
        // Slave bytes, one cut short by deselect
        slv_sel = 1'b0;
        tx = 8'(xs());
        wr(DT, tx);
        rp = 8'(xs());
        ssd_spi_partner_i.send(rp, 8, d);
        `CHK(d, tx)
        wd();
        rd(DT, d);
        `CHK(d, rp)
        ssd_spi_partner_i.send(8'(xs()), 3, d);
        rp = 8'(xs());
        ssd_spi_partner_i.send(rp, 8, d);
        wd();
        rd(DT, d);
        `CHK(d, rp)
        finish_test();
    end
endmodule : test_spi_status_and_data_port
